// ==== core/ls_lanes_defines.svh ====
// offsets, field positions, reset values and fixed addends of the load/store lanes
// Summary of operation
// - S clear, H set: unsigned halfword transfer.
// - S set: H picks signed byte/half load.
// - signed byte: bit 7 fills bits 31..8.
// - signed half: bit 15 fills bits 31..16.
// - endianness setting steers lane selection.
// - little endian byte lanes climb from 7..0.
// - little endian half: A1 picks bits 31..16.
// - big endian byte lanes fall from 31..24.
// - big endian half: A1 picks bits 15..0.
// - unsigned half load zeroes upper sixteen bits.
// - halfword store repeats low half twice.
// - counter as base reads instruction plus 8.
// - counter stored by store_half is plus 12.
// - abort input takes the data abort trap.
// - cycle costs 1S1N1I, 2S2N1I, 2N.
`ifndef LS_LANES_DEFINES_SVH
`define LS_LANES_DEFINES_SVH

`define CTRL_OFF           8'h00
`define STATUS_OFF         8'h04
`define LAST_DATA_OFF      8'h08
`define CTRL_ENDIAN_BIT    0
`define STATUS_BUSY_BIT    0
`define STATUS_ABORT_BIT   1
`define STATUS_ILLEGAL_BIT 2
`define CTRL_RESET         1'b0
`define PC_BASE_ADDEND     32'h0000_0008
`define PC_STORE_ADDEND    32'h0000_000C

`endif

// ==== core/ls_lanes_pkg.sv ====
// types shared by the load/store lane datapath
package ls_lanes_pkg;

	typedef enum logic [2:0] {
		ST_IDLE     = 3'b000,
		ST_ADDR     = 3'b001,
		ST_DATA     = 3'b010,
		ST_INT      = 3'b011,
		ST_REFILL_N = 3'b100,
		ST_REFILL_S = 3'b101,
		ST_SEQ      = 3'b110
	} phase_e;

	typedef enum logic [1:0] {
		CYC_IDLE = 2'b00,
		CYC_N    = 2'b01,
		CYC_S    = 2'b10,
		CYC_I    = 2'b11
	} cycle_e;

	typedef struct packed {
		logic        valid;
		logic        load;
		logic        sign;
		logic        half;
		logic [31:0] instr_addr;
		logic        base_is_pc;
		logic [31:0] base_val;
		logic [31:0] offset_val;
		logic        src_is_pc;
		logic [31:0] src_val;
		logic        dest_is_pc;
	} cmd_s;

	typedef struct packed {
		cycle_e      cycle;
		logic        active;
		logic        write;
		logic        half;
		logic [31:0] addr;
		logic [31:0] wdata;
	} mem_req_s;

	typedef struct packed {
		logic [31:0] rdata;
		logic        abort;
	} mem_rsp_s;

	typedef struct packed {
		logic        valid;
		logic        abort;
		logic        dest_is_pc;
		logic [31:0] data;
	} result_s;

	typedef struct packed {
		phase_e      phase;
		logic        load;
		logic        sign;
		logic        half;
		logic        dest_pc;
		mem_req_s    mem;
		result_s     res;
		logic        cmd_ready;
		logic        endian_select;
		logic        abort_seen;
		logic        illegal_seen;
		logic [31:0] last_data;
		logic        dp_write;
		logic [7:0]  dp_addr;
		logic [31:0] hrdata;
		logic        hreadyout;
		logic        hresp;
	} state_s;

endpackage

// ==== core/halfword_signed_load_store_lanes.sv ====
// halfword and signed byte/halfword load/store datapath with an ahb-lite register slave
`timescale 1ns/10ps
`include "ls_lanes_defines.svh"

module halfword_signed_load_store_lanes (
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic                       hreadyout,
	output logic                       hresp,
	output logic [31:0]                hrdata,
	input  wire ls_lanes_pkg::cmd_s    cmd,
	output logic                       cmd_ready,
	output ls_lanes_pkg::mem_req_s     mem_req,
	input  wire ls_lanes_pkg::mem_rsp_s mem_rsp,
	output ls_lanes_pkg::result_s      result
);

	ls_lanes_pkg::state_s r;
	ls_lanes_pkg::state_s n;

	// both counter-relative values are the instruction address plus a fixed addend
	function automatic logic [31:0] pc_plus(
		input logic [31:0] ia,
		input logic [31:0] addend
	);
		return ia + addend;
	endfunction

	// status word as read back; field positions come from the shared defines
	function automatic logic [31:0] status_word(
		input logic busy,
		input logic abort_flag,
		input logic illegal_flag
	);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`STATUS_BUSY_BIT]    = busy;
		w[`STATUS_ABORT_BIT]   = abort_flag;
		w[`STATUS_ILLEGAL_BIT] = illegal_flag;
		return w;
	endfunction

	// byte lane per byte order; a table keeps both orders visible side by side
	function automatic logic [7:0] pick_byte(
		input logic [31:0] bus,
		input logic [1:0]  a,
		input logic        big
	);
		logic [7:0] b;
		b = 8'h00;
		case ({big, a})
			3'b000: begin
				b = bus[7:0];
			end
			3'b001: begin
				b = bus[15:8];
			end
			3'b010: begin
				b = bus[23:16];
			end
			3'b011: begin
				b = bus[31:24];
			end
			3'b100: begin
				b = bus[31:24];
			end
			3'b101: begin
				b = bus[23:16];
			end
			3'b110: begin
				b = bus[15:8];
			end
			3'b111: begin
				b = bus[7:0];
			end
			default: begin
				b = 8'h00;
			end
		endcase
		return b;
	endfunction

	// halfword lane; address bit 0 is ignored, an odd address gives the half that bit 1 selects
	function automatic logic [15:0] pick_half(
		input logic [31:0] bus,
		input logic        a1,
		input logic        big
	);
		logic [15:0] hw;
		hw = 16'h0000;
		case ({big, a1})
			2'b00: begin
				hw = bus[15:0];
			end
			2'b01: begin
				hw = bus[31:16];
			end
			2'b10: begin
				hw = bus[31:16];
			end
			2'b11: begin
				hw = bus[15:0];
			end
			default: begin
				hw = 16'h0000;
			end
		endcase
		return hw;
	endfunction

	// lane pick plus extension; pure logic so the pick lands in the capture cycle
	function automatic logic [31:0] lane_extend(
		input logic [31:0] bus,
		input logic [1:0]  a,
		input logic        big,
		input logic        sign,
		input logic        half
	);
		logic [7:0]  b;
		logic [15:0] hw;
		logic [31:0] res;
		b  = pick_byte(bus, a, big);
		hw = pick_half(bus, a[1], big);
		if (!half) begin
			res = {{24{b[7]}}, b};
		end else if (sign) begin
			res = {{16{hw[15]}}, hw};
		end else begin
			res = {16'h0000, hw};
		end
		return res;
	endfunction

	// swap encoding and signed stores fall outside this datapath
	function automatic logic not_ours(input ls_lanes_pkg::cmd_s c);
		return (!c.sign && !c.half) || (c.sign && !c.load);
	endfunction

	logic [31:0] base_now;
	logic [31:0] src_now;
	logic [31:0] addr_now;

	// address and store data come straight from the command
	assign base_now = cmd.base_is_pc ? pc_plus(cmd.instr_addr, `PC_BASE_ADDEND)
		: cmd.base_val;
	assign src_now  = cmd.src_is_pc ? pc_plus(cmd.instr_addr, `PC_STORE_ADDEND)
		: cmd.src_val;
	assign addr_now = base_now + cmd.offset_val;

	// next-state of the whole block
	always_comb begin
		n = r;
		n.res.valid = 1'b0;
		n.res.abort = 1'b0;

		// bus data phase: writes land here, w1c status before the fsm sets
		if (r.dp_write) begin
			case (r.dp_addr)
				`CTRL_OFF: begin
					n.endian_select = hwdata[`CTRL_ENDIAN_BIT];
				end
				`STATUS_OFF: begin
					n.abort_seen   = r.abort_seen & ~hwdata[`STATUS_ABORT_BIT];
					n.illegal_seen = r.illegal_seen & ~hwdata[`STATUS_ILLEGAL_BIT];
				end
				default: begin
				end
			endcase
		end
		n.dp_write = 1'b0;

		// transfer sequencer; mem_req is set on entry so it shows during the phase
		case (r.phase)
			ls_lanes_pkg::ST_IDLE: begin
				n.mem = '0;
				n.mem.cycle = ls_lanes_pkg::CYC_IDLE;
				if (cmd.valid && r.cmd_ready) begin
					if (not_ours(cmd)) begin
						n.illegal_seen = 1'b1;                   // dropped, flagged
					end else begin
						n.cmd_ready   = 1'b0;
						n.load        = cmd.load;
						n.sign        = cmd.sign;
						n.half        = cmd.half;
						n.dest_pc     = cmd.dest_is_pc && cmd.load;
						n.mem.addr    = addr_now;
						n.mem.half    = cmd.half;
						n.mem.wdata   = {src_now[15:0], src_now[15:0]};
						n.mem.cycle   = ls_lanes_pkg::CYC_N;
						if (cmd.load) begin
							n.phase      = ls_lanes_pkg::ST_DATA;
							n.mem.active = 1'b1;
						end else begin
							n.phase      = ls_lanes_pkg::ST_ADDR;    // first N of a store
						end
					end
				end
			end
			ls_lanes_pkg::ST_ADDR: begin
				n.phase      = ls_lanes_pkg::ST_DATA;
				n.mem.cycle  = ls_lanes_pkg::CYC_N;              // second N
				n.mem.active = 1'b1;
				n.mem.write  = 1'b1;
			end
			ls_lanes_pkg::ST_DATA: begin
				n.mem.active = 1'b0;
				n.mem.write  = 1'b0;
				n.res.dest_is_pc = r.dest_pc;
				if (mem_rsp.abort) begin
					// no register update so the instruction can restart
					n.res.valid  = 1'b1;
					n.res.abort  = 1'b1;
					n.res.data   = 32'h0000_0000;
					n.abort_seen = 1'b1;
					n.phase      = ls_lanes_pkg::ST_IDLE;
					n.mem.cycle  = ls_lanes_pkg::CYC_IDLE;
					n.cmd_ready  = 1'b1;
				end else if (r.load) begin
					n.res.valid = 1'b1;
					n.res.data  = lane_extend(mem_rsp.rdata, r.mem.addr[1:0], r.endian_select,
						r.sign, r.half);
					n.last_data = n.res.data;
					n.phase     = ls_lanes_pkg::ST_INT;
					n.mem.cycle = ls_lanes_pkg::CYC_I;
				end else begin
					n.res.valid = 1'b1;
					n.res.data  = 32'h0000_0000;
					n.phase     = ls_lanes_pkg::ST_IDLE;
					n.mem.cycle = ls_lanes_pkg::CYC_IDLE;
					n.cmd_ready = 1'b1;
				end
			end
			ls_lanes_pkg::ST_INT: begin
				if (r.dest_pc) begin
					n.phase     = ls_lanes_pkg::ST_REFILL_N;     // pipeline refill
					n.mem.cycle = ls_lanes_pkg::CYC_N;
				end else begin
					n.phase     = ls_lanes_pkg::ST_SEQ;
					n.mem.cycle = ls_lanes_pkg::CYC_S;
				end
			end
			ls_lanes_pkg::ST_REFILL_N: begin
				n.phase     = ls_lanes_pkg::ST_REFILL_S;
				n.mem.cycle = ls_lanes_pkg::CYC_S;
			end
			ls_lanes_pkg::ST_REFILL_S: begin
				n.phase     = ls_lanes_pkg::ST_SEQ;
				n.mem.cycle = ls_lanes_pkg::CYC_S;
			end
			ls_lanes_pkg::ST_SEQ: begin
				n.phase     = ls_lanes_pkg::ST_IDLE;
				n.mem.cycle = ls_lanes_pkg::CYC_IDLE;
				n.cmd_ready = 1'b1;
			end
			default: begin
				n.phase     = ls_lanes_pkg::ST_IDLE;
				n.mem       = '0;
				n.cmd_ready = 1'b1;
			end
		endcase

		// bus address phase; read data reflects this cycle's updates
		if (hsel && htrans[1] && hready) begin
			n.dp_write = hwrite;
			n.dp_addr  = haddr[7:0];
			if (!hwrite) begin
				case (haddr[7:0])
					`CTRL_OFF: begin
						n.hrdata = 32'h0000_0000;
						n.hrdata[`CTRL_ENDIAN_BIT] = n.endian_select;
					end
					`STATUS_OFF: begin
						n.hrdata = status_word(n.phase != ls_lanes_pkg::ST_IDLE, n.abort_seen,
							n.illegal_seen);
					end
					`LAST_DATA_OFF: begin
						n.hrdata = n.last_data;
					end
					default: begin
						n.hrdata = 32'h0000_0000;            // unmapped reads zero, okay
					end
				endcase
			end
		end
		n.hreadyout = 1'b1;
		n.hresp     = 1'b0;
	end

	// single state register; async reset to constants only
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r               <= '0;
			r.phase         <= ls_lanes_pkg::ST_IDLE;
			r.mem.cycle     <= ls_lanes_pkg::CYC_IDLE;
			r.cmd_ready     <= 1'b1;
			r.endian_select <= `CTRL_RESET;
			r.hreadyout     <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// outputs all straight from the state register
	assign hreadyout = r.hreadyout;
	assign hresp     = r.hresp;
	assign hrdata    = r.hrdata;
	assign cmd_ready = r.cmd_ready;
	assign mem_req   = r.mem;
	assign result    = r.res;

endmodule // halfword_signed_load_store_lanes

// ==== tb/ls_lanes_sva.sv ====
// assertions on the load/store lane datapath ports
`timescale 1ns/10ps
module ls_lanes_sva (
	input wire logic                   hclk,
	input wire logic                   hresetn,
	input wire ls_lanes_pkg::cmd_s     cmd,
	input wire logic                   cmd_ready,
	input wire ls_lanes_pkg::mem_req_s mem_req,
	input wire ls_lanes_pkg::mem_rsp_s mem_rsp,
	input wire ls_lanes_pkg::result_s  result
);
	logic sg_reg;
	logic hf_reg;
	logic pc_reg;
	wire  tk = cmd.valid && cmd_ready && (cmd.sign ? cmd.load : cmd.half);
	wire  ok = result.valid && !result.abort;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// kind of the command in flight, so results can be judged
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			{sg_reg, hf_reg, pc_reg} <= 3'b000;
		else if (tk)
			{sg_reg, hf_reg, pc_reg} <= {cmd.sign, cmd.half, cmd.dest_is_pc && cmd.load};
	end
	// bus phases of a transfer
	sequence n_act;
		mem_req.cycle == ls_lanes_pkg::CYC_N && mem_req.active;
	endsequence
	sequence i_then_s;
		mem_req.cycle == ls_lanes_pkg::CYC_I ##1 mem_req.cycle == ls_lanes_pkg::CYC_S;
	endsequence
	a_load_cycles: assert property (tk && cmd.load && !cmd.dest_is_pc |=>
		n_act ##1 (result.abort or i_then_s)) else $error("load cycle order wrong");
	a_store_cycles: assert property (tk && !cmd.load |=>
		!mem_req.active ##1 n_act ##0 mem_req.write) else $error("store cycle order wrong");
	a_store_dup: assert property (mem_req.active && mem_req.write |->
		mem_req.wdata[31:16] == mem_req.wdata[15:0]) else $error("store half not repeated");
	a_pc_store: assert property (tk && !cmd.load && cmd.src_is_pc |-> ##2
		mem_req.wdata[15:0] == $past(cmd.instr_addr[15:0], 2) + 16'h000C)
		else $error("counter store value wrong");
	a_abort_trap: assert property (mem_req.active && mem_rsp.abort |=>
		result.valid && result.abort) else $error("abort not reported");
	a_sign_byte: assert property (ok && sg_reg && !hf_reg |->
		result.data[31:8] == {24{result.data[7]}}) else $error("byte sign fill wrong");
	a_sign_half: assert property (ok && sg_reg && hf_reg |->
		result.data[31:16] == {16{result.data[15]}}) else $error("half sign fill wrong");
	a_zero_half: assert property (ok && !sg_reg |->
		result.data[31:16] == 16'h0000) else $error("upper half not zero");
	a_dest_flag: assert property (ok |->
		result.dest_is_pc == pc_reg) else $error("destination flag wrong");
endmodule // ls_lanes_sva

bind halfword_signed_load_store_lanes ls_lanes_sva ls_lanes_sva_i (.hclk, .hresetn, .cmd,
	.cmd_ready, .mem_req, .mem_rsp, .result);

// ==== tb/ls_mem_model.sv ====
// memory system model facing the lane datapath
`timescale 1ns/10ps
module ls_mem_model (
	input  wire logic                   hclk,
	input  wire logic                   big,
	input  wire logic                   abort_en,
	input  wire ls_lanes_pkg::mem_req_s mem_req,
	output ls_lanes_pkg::mem_rsp_s      mem_rsp
);
	logic [31:0] mem [0:63];
	logic [31:0] junk = 32'h5a5a_0001;
	logic        up;
	// moving pattern outside a read so no stale word passes
	always_comb begin
		mem_rsp.rdata = (mem_req.active && !mem_req.write) ? mem[mem_req.addr[7:2]] : junk;
		mem_rsp.abort = mem_req.active && abort_en;
		up = mem_req.addr[1] ^ big;
	end
	// only the addressed half is written; an aborted store leaves memory alone
	always @(posedge hclk) begin
		junk <= {junk[30:0], ~junk[31]};
		if (mem_req.active && mem_req.write && !abort_en) begin
			if (up)
				mem[mem_req.addr[7:2]][31:16] <= mem_req.wdata[31:16];
			else
				mem[mem_req.addr[7:2]][15:0] <= mem_req.wdata[15:0];
		end
	end
endmodule // ls_mem_model

// ==== tb/halfword_signed_load_store_lanes_tb.sv ====
// self-checking bench for the load/store lane datapath
`timescale 1ns/10ps
`include "ls_lanes_defines.svh"
module halfword_signed_load_store_lanes_tb;
	localparam logic [31:0] wv = 32'h817f_02fe;
	logic                   hclk = 1'b0;
	logic                   hresetn = 1'b0;
	logic                   hsel = 1'b1;
	logic                   hwrite = 1'b0;
	logic                   abort_en = 1'b0;
	logic                   e = 1'b0;
	logic                   ab;
	logic [1:0]             htrans = 2'b00;
	logic [31:0]            haddr = 32'h0;
	logic [31:0]            hwdata = 32'h0;
	logic [31:0]            rd;
	logic [31:0]            d;
	logic [15:0]            h;
	logic [7:0]             b;
	wire                    hready;
	wire                    hresp;
	wire                    cmd_ready;
	wire [31:0]             hrdata;
	ls_lanes_pkg::cmd_s     cmd = '0;
	ls_lanes_pkg::mem_req_s mem_req;
	ls_lanes_pkg::mem_rsp_s mem_rsp;
	ls_lanes_pkg::result_s  result;
	int                     miscompares = 0;
	int                     samples_checked = 0;
	int                     n;
	int                     n0;

	halfword_signed_load_store_lanes halfword_signed_load_store_lanes_i (.hclk, .hresetn, .hsel,
		.haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata, .hready, .hreadyout(hready), .hresp,
		.hrdata, .cmd, .cmd_ready, .mem_req, .mem_rsp, .result);
	ls_mem_model ls_mem_model_i (.hclk, .big(e), .abort_en, .mem_req, .mem_rsp);

	// core clock
	always #5 hclk = ~hclk;

	task results();
		$display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
		if (miscompares == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x);
		samples_checked++;
		if (g !== x) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, g, x);
		end
	endtask
	// every wait is bounded; a hang ends the run
	task tmo(input logic bad);
		if (bad !== 1'b0) begin
			miscompares++;
			$display("unexpected at %0t: handshake timeout", $time);
			results();
		end
	endtask
	task wait_hready();
		int i;
		i = 0;
		do begin
			@(posedge hclk);
			i++;
		end while (!hready && i < 40);
		tmo(!hready);
	endtask
	// single word transfer: address phase, then data phase
	task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		htrans <= 2'b10;
		haddr <= {24'h00_0000, a};
		hwrite <= wr;
		wait_hready();
		htrans <= 2'b00;
		hwdata <= wd;
		wait_hready();
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask
	// flags: load, sign, half, pc base, pc source, pc destination
	task op(input logic [5:0] f, input logic [31:0] off);
		cmd <= '{1'b1, f[5], f[4], f[3], 32'h0000_0200, f[2], 32'h0000_0040, off, f[1],
			32'h1234_abcd, f[0]};
		@(posedge hclk);
		cmd <= '0;
		d = 'x;
		ab = 1'b0;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
			if (result.valid)
				{ab, d} = {result.abort, result.data};
		end while (!cmd_ready && n < 40);
		tmo(!cmd_ready);
	endtask

	// byte lanes for every offset, half lanes for even offsets, in both byte orders, then counter, store, abort, refusal
	initial begin
		ls_mem_model_i.mem[16] = wv;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		for (int en = 0; en < 2; en++) begin
			e <= en[0];
			ahb(1'b1, `CTRL_OFF, {31'h0, en[0]});
			for (int a = 0; a < 4; a++) begin
				b = wv[8 * (en[0] ? 3 - a : a) +: 8];
				h = wv[16 * (en[0] ^ a[1]) +: 16];
				op(6'b110000, a);
				chk(d, {{24{b[7]}}, b});
				if (!a[0]) begin
					op(6'b111000, a);
					chk(d, {{16{h[15]}}, h});
					op(6'b101000, a);
					chk(d, {16'h0000, h});
					n0 = n;
				end
			end
		end
		op(6'b101100, 32'h0000_0038);
		chk(d, {16'h0000, wv[31:16]});
		op(6'b101101, 32'h0000_0038);
		chk(n, n0 + 2);
		op(6'b001000, 32'h0000_0002);
		chk(n, n0 - 1);
		chk(ls_mem_model_i.mem[16], {wv[31:16], 16'habcd});
		op(6'b001010, 32'h0);
		chk(ls_mem_model_i.mem[16], 32'h020c_abcd);
		abort_en <= 1'b1;
		op(6'b101000, 32'h0);
		abort_en <= 1'b0;
		chk(ab, 1'b1);
		op(6'b010000, 32'h0);
		chk(d, 'x);
		ahb(1'b0, `STATUS_OFF, 32'h0);
		chk(rd[`STATUS_ILLEGAL_BIT], 1'b1);
		chk(rd[`STATUS_ABORT_BIT], 1'b1);
		ahb(1'b0, `LAST_DATA_OFF, 32'h0);
		chk(rd, {16'h0000, wv[31:16]});
		ahb(1'b1, `STATUS_OFF, 32'h0000_0006);
		ahb(1'b0, `STATUS_OFF, 32'h0);
		chk(rd, 32'h0);
		op(6'b100000, 32'h0);
		ahb(1'b0, `STATUS_OFF, 32'h0);
		chk(rd, 32'h0000_0004);
		ahb(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0);
		results();
	end
endmodule // halfword_signed_load_store_lanes_tb
